// >>> hw/dse_display_identification_table_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module dse_display_identification_table_ctrl
  import dse_pkg::*;
#(
  parameter logic [31:0] MAKER_CODE = 32'h1a2b3c4d  // Arbitrary value
)(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Source selection
  input  wire logic [1:0]   mode_sel_pin,
  input  wire logic         mode_ovr_en,
  input  wire dse_src_t     mode_ovr,
  // Display data channel pins
  input  wire logic         ddc_scl_i,
  input  wire logic         ddc_sda_i,
  output logic              ddc_sda_o,
  output logic              ddc_sda_oe_n,
  // Local eeprom pins
  input  wire logic         eep_sda_i,
  output logic              eep_scl_o,
  output logic              eep_scl_oe_n,
  output logic              eep_sda_o,
  output logic              eep_sda_oe_n,
  // Store access port
  input  wire dse_st_req_t  st_req,
  output logic              st_done,
  output logic [7:0]        st_rdata,
  // Bridged control channel
  input  wire dse_bcc_req_t ext_req,
  output var dse_bcc_rsp_t  ext_rsp,
  output var dse_bcc_req_t  bcc_req,
  input  wire dse_bcc_rsp_t bcc_rsp,
  // Hot plug and link status
  input  wire logic         pwr5v_pin,
  input  wire logic         video_ready,
  input  wire logic         tmds_div_pin,
  output logic              hot_plug_indicator_o,
  output logic              hot_plug_indicator_oe_n,
  output logic              table_ok,
  output logic              tmds_ok,
  // Consumer control bus timing
  input  wire logic         cec_ref_sel,
  input  wire logic         cec_ref_pin,
  output logic              cec_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int NPIN = 8;
  wire  [NPIN-1:0] pin_raw = {tmds_div_pin, cec_ref_pin, pwr5v_pin,
                              eep_sda_i, ddc_sda_i, ddc_scl_i, mode_sel_pin};
  logic [NPIN-1:0] pin_s;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      logic m_q;
      logic s_q;
      always_ff @(posedge mclk)
      begin
        m_q <= pin_raw[gi];
        s_q <= m_q;
      end
      assign pin_s[gi] = s_q;
    end
  endgenerate

  wire [1:0] strap_s = pin_s[1:0];
  wire       scl_s   = pin_s[2];
  wire       sda_s   = pin_s[3];
  wire       esda_s  = pin_s[4];
  wire       pwr5v_s = pin_s[5];
  wire       cref_s  = pin_s[6];
  wire       tdiv_s  = pin_s[7];

  ////////////////////////////////////////////////////////////////////////////
  // Source selection; strap caught after reset release
  logic     cap_q;
  logic     start_q;
  dse_src_t strap_q;
  dse_src_t mode_q;

  wire dse_src_t mode_d = mode_ovr_en ? mode_ovr : strap_q;
  wire           restart = start_q | (cap_q & (mode_d != mode_q));

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cap_q   <= 1'b0;
      start_q <= 1'b0;
      strap_q <= dse_src_t'(MODE_RST);
      mode_q  <= dse_src_t'(MODE_RST);
    end
    else
    begin
      cap_q   <= 1'b1;
      start_q <= ~cap_q;
      if (~cap_q)
        strap_q <= dse_src_t'(strap_s);
      if (cap_q)
        mode_q <= mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fused default profile, first byte in the top lane of row 0
  localparam logic [127:0] FUSE_ROW [16] = '{
    {64'h00ffffffffffff00, MAKER_CODE, 32'h01000000},
    128'h1c180103803420780aec18a354469825,
    128'h0f484c00000001010101010101010101,
    128'h010101010101011d007251d01e206e50,
    128'h55000020210000180000_00fd003b3d62,
    128'h6408000a202020202020000000fc0054,
    128'h492d4453393055783934390a00000010,
    128'h00000000000000000000000000000157,
    128'h0203154041842309_7f058301_00006603,
    128'h0c001000000000000000000000000000,
    128'h0, 128'h0, 128'h0, 128'h0, 128'h0, 128'h0
  };

  ////////////////////////////////////////////////////////////////////////////
  // Internal store, volatile and uninitialised
  logic [7:0] store [STORE_DEPTH];
  logic [7:0] ddc_addr;
  wire  [7:0] ddc_data = store[ddc_addr];

  ////////////////////////////////////////////////////////////////////////////
  // Loader for fused and remote sources
  typedef enum logic [5:0] {
    L_IDLE  = 6'h01,
    L_FUSE  = 6'h02,
    L_REQ   = 6'h04,
    L_WAIT  = 6'h08,
    L_RETRY = 6'h10,
    L_DONE  = 6'h20
  } dse_ld_st_t;

  dse_ld_st_t ld_q;
  logic [7:0] idx_q;
  logic [11:0] tmr_q;
  logic       sram_loaded_q;

  logic       busy_q;
  logic       own_ext_q;
  logic       pend_q;
  logic       ext_prev_q;

  wire        grant_ext = ~busy_q & pend_q;
  wire        grant_cpy = ~busy_q & ~pend_q & (ld_q == L_REQ);
  wire        cpy_done  = busy_q & ~own_ext_q & bcc_rsp.done;
  wire [7:0]  fuse_byte = FUSE_ROW[idx_q[7:4]][{~idx_q[3:0], 3'b000} +: 8];
  wire        fuse_we   = (ld_q == L_FUSE);
  wire        copy_we   = (ld_q == L_WAIT) & cpy_done & ~bcc_rsp.nak;
  wire        ld_we     = fuse_we | copy_we;
  wire [7:0]  ld_wdata  = fuse_we ? fuse_byte : bcc_rsp.rdata;
  // Loader owns the write port; a colliding host write gets no done
  wire        host_we   = st_req.req & st_req.we & ~ld_we;
  wire        last_byte = (idx_q == STORE_LAST);

  always_ff @(posedge mclk)
  begin
    if (ld_we)
      store[idx_q] <= ld_wdata;
    else if (host_we)
      store[st_req.addr] <= st_req.wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (rst | restart)
    begin
      idx_q <= 8'h00;
      tmr_q <= 12'h000;
      if (rst)
        ld_q <= L_IDLE;
      else if (mode_d == SRC_FUSED)
        ld_q <= L_FUSE;
      else if (mode_d == SRC_REMOTE)
        ld_q <= L_REQ;
      else
        ld_q <= L_IDLE;
    end
    else
    begin
      case (ld_q)
        L_FUSE:
        begin
          idx_q <= idx_q + 8'h01;
          if (last_byte)
            ld_q <= L_DONE;
        end
        L_REQ:
          if (grant_cpy)
            ld_q <= L_WAIT;
        L_WAIT:
          if (cpy_done)
          begin
            if (bcc_rsp.nak)
            begin
              // Table absent: probe again from the start later
              idx_q <= 8'h00;
              tmr_q <= 12'(RETRY_CYC - 1);
              ld_q  <= L_RETRY;
            end
            else
            begin
              idx_q <= idx_q + 8'h01;
              ld_q  <= last_byte ? L_DONE : L_REQ;
            end
          end
        L_RETRY:
        begin
          tmr_q <= tmr_q - 12'h001;
          if (tmr_q == 12'h000)
            ld_q <= L_REQ;
        end
        L_IDLE, L_DONE:
          ld_q <= ld_q;
        default:
          ld_q <= L_IDLE;
      endcase
    end
  end

  // Store has no content until a master writes it
  always_ff @(posedge mclk)
  begin
    if (rst)
      sram_loaded_q <= 1'b0;
    else if (host_we)
      sram_loaded_q <= 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_done  <= 1'b0;
      st_rdata <= 8'h00;
    end
    else
    begin
      st_done  <= st_req.req & ~(st_req.we & ld_we);
      st_rdata <= store[st_req.addr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bridged channel arbiter; external master wins a tie
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      busy_q     <= 1'b0;
      own_ext_q  <= 1'b0;
      pend_q     <= 1'b0;
      ext_prev_q <= 1'b0;
      bcc_req    <= '0;
      ext_rsp    <= '0;
    end
    else
    begin
      ext_prev_q <= ext_req.req;
      if (ext_req.req & ~ext_prev_q)
        pend_q <= 1'b1;
      else if (grant_ext)
        pend_q <= 1'b0;
      ext_rsp <= (busy_q & own_ext_q & bcc_rsp.done) ? bcc_rsp : '0;
      if (grant_ext)
      begin
        busy_q    <= 1'b1;
        own_ext_q <= 1'b1;
        bcc_req   <= ext_req;
      end
      else if (grant_cpy)
      begin
        busy_q    <= 1'b1;
        own_ext_q <= 1'b0;
        bcc_req   <= '{req: 1'b1, we: 1'b0, dev: DDC_DEV_ADDR,
                       addr: idx_q, wdata: 8'h00};
      end
      else if (busy_q & bcc_rsp.done)
      begin
        busy_q      <= 1'b0;
        bcc_req.req <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel slave on the store, off in eeprom mode
  logic slv_low;
  wire  slv_en = (mode_q != SRC_EEPROM) & cap_q;

  dse_ddc_slave u_slave (
    .mclk    (mclk),
    .rst     (rst),
    .enable  (slv_en),
    .scl_s   (scl_s),
    .sda_s   (sda_s),
    .rd_addr (ddc_addr),
    .rd_data (ddc_data),
    .sda_low (slv_low)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Eeprom pass-through; whoever pulls data low first owns it
  logic       fwd_h_q;
  logic       fwd_e_q;
  logic [1:0] hold_q;
  wire        eep_mode = (mode_q == SRC_EEPROM) & cap_q;

  always_ff @(posedge mclk)
  begin
    if (rst | ~eep_mode)
    begin
      fwd_h_q <= 1'b0;
      fwd_e_q <= 1'b0;
      hold_q  <= 2'h0;
    end
    else if (fwd_h_q & sda_s)
    begin
      fwd_h_q <= 1'b0;
      hold_q  <= 2'h3;
    end
    else if (fwd_e_q & esda_s)
    begin
      fwd_e_q <= 1'b0;
      hold_q  <= 2'h3;
    end
    // Hold-off masks our own release echoing back through sync
    else if (hold_q != 2'h0)
      hold_q <= hold_q - 2'h1;
    else if (~fwd_h_q & ~fwd_e_q)
    begin
      fwd_h_q <= ~sda_s;
      fwd_e_q <= sda_s & ~esda_s;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ddc_sda_o    <= 1'b0;
      ddc_sda_oe_n <= 1'b1;
      eep_scl_o    <= 1'b0;
      eep_scl_oe_n <= 1'b1;
      eep_sda_o    <= 1'b0;
      eep_sda_oe_n <= 1'b1;
    end
    else
    begin
      ddc_sda_oe_n <= ~(slv_low | fwd_e_q);
      eep_scl_oe_n <= ~(eep_mode & ~scl_s);
      eep_sda_oe_n <= ~fwd_h_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // TMDS clock range check on a divided clock pin
  logic [10:0] win_q;
  logic [7:0]  edg_q;
  logic        tdiv_p_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      win_q    <= 11'h000;
      edg_q    <= 8'h00;
      tdiv_p_q <= 1'b0;
      tmds_ok  <= 1'b0;
    end
    else
    begin
      tdiv_p_q <= tdiv_s;
      if (win_q == 11'(TMDS_WIN_CYC - 1))
      begin
        win_q   <= 11'h000;
        edg_q   <= 8'h00;
        tmds_ok <= (edg_q >= 8'(TMDS_MIN_CNT))
                 & (edg_q <= 8'(TMDS_MAX_CNT));
      end
      else
      begin
        win_q <= win_q + 11'h001;
        if (tdiv_s & ~tdiv_p_q & (edg_q != 8'hff))
          edg_q <= edg_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hot plug: released only once 5 V, clock, table and video are ready
  wire src_ok = (mode_q == SRC_EEPROM) | (ld_q == L_DONE)
              | ((mode_q == SRC_SRAM) & sram_loaded_q);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      table_ok                <= 1'b0;
      hot_plug_indicator_o    <= 1'b0;
      hot_plug_indicator_oe_n <= 1'b0;
    end
    else
    begin
      table_ok                <= src_ok & cap_q & ~restart;
      hot_plug_indicator_oe_n <= pwr5v_s & tmds_ok & table_ok
                               & video_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bus tick from reference pin or internal divider
  logic [7:0] div_q;
  logic       cref_p_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      div_q    <= 8'h00;
      cref_p_q <= 1'b0;
      cec_tick <= 1'b0;
    end
    else
    begin
      cref_p_q <= cref_s;
      div_q    <= (div_q == 8'(CEC_TICK_CYC - 1)) ? 8'h00 : div_q + 8'h01;
      cec_tick <= cec_ref_sel ? (cref_s & ~cref_p_q)
                              : (div_q == 8'h00);
    end
  end

endmodule
`default_nettype wire

// >>> shared/dse_pkg.sv
`default_nettype none
package dse_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Display data channel addressing
  localparam logic [6:0] DDC_DEV_ADDR  = 7'h50;  // 0xa0 as a write byte
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam int         STORE_DEPTH   = 256;
  localparam logic [7:0] STORE_LAST    = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int MCLK_MHZ         = 25;
  localparam int CEC_TICK_NS      = 1000;
  localparam int CEC_TICK_CYC     = (CEC_TICK_NS * MCLK_MHZ) / 1000;
  localparam int RETRY_US         = 100;
  localparam int RETRY_CYC        = RETRY_US * MCLK_MHZ;
  localparam int TMDS_MIN_MHZ     = 25;
  localparam int TMDS_MAX_MHZ     = 96;
  localparam int TMDS_DIV         = 64;
  localparam int TMDS_WIN_CYC     = 1024;
  // Least rate rounds up, greatest rate rounds down
  localparam int TMDS_MIN_CNT     = (TMDS_MIN_MHZ * TMDS_WIN_CYC
                                     + TMDS_DIV * MCLK_MHZ - 1)
                                    / (TMDS_DIV * MCLK_MHZ);
  localparam int TMDS_MAX_CNT     = (TMDS_MAX_MHZ * TMDS_WIN_CYC)
                                    / (TMDS_DIV * MCLK_MHZ);

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [1:0] MODE_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    SRC_EEPROM = 2'h0,
    SRC_SRAM   = 2'h1,
    SRC_REMOTE = 2'h2,
    SRC_FUSED  = 2'h3
  } dse_src_t;

  typedef struct packed {
    logic       req;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dse_st_req_t;

  typedef struct packed {
    logic       req;
    logic       we;
    logic [6:0] dev;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dse_bcc_req_t;

  typedef struct packed {
    logic       done;
    logic       nak;
    logic [7:0] rdata;
  } dse_bcc_rsp_t;

endpackage
`default_nettype wire

// >>> hw/dse_ddc_slave.sv
`timescale 1ns/1ps
`default_nettype none
module dse_ddc_slave
  import dse_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Synchronised bus levels
  input  wire logic       enable,
  input  wire logic       scl_s,
  input  wire logic       sda_s,
  // Table access
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data,
  // Data line drive, high pulls low
  output logic            sda_low
);

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_ADDR  = 7'h02,
    S_AACK  = 7'h04,
    S_WOFS  = 7'h08,
    S_WACK  = 7'h10,
    S_RDATA = 7'h20,
    S_RACK  = 7'h40
  } dse_ddc_st_t;

  dse_ddc_st_t st_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sh_q;
  logic [7:0]  tx_q;
  logic [7:0]  ofs_q;
  logic        rw_q;
  logic        mack_q;
  logic        low_q;
  logic        scl_p_q;
  logic        sda_p_q;

  ////////////////////////////////////////////////////////////////////////////
  wire scl_rise  = scl_s & ~scl_p_q;
  wire scl_fall  = ~scl_s & scl_p_q;
  wire bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire byte_done = (cnt_q == BYTE_BITS);
  wire addr_hit  = (sh_q[7:1] == DDC_DEV_ADDR);

  assign rd_addr = ofs_q;
  assign sda_low = low_q;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk)
  begin
    if (rst | ~enable)
    begin
      st_q    <= S_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      tx_q    <= 8'h00;
      ofs_q   <= 8'h00;
      rw_q    <= 1'b0;
      mack_q  <= 1'b0;
      low_q   <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      if (bus_start)
      begin
        st_q  <= S_ADDR;
        cnt_q <= 4'h0;
        low_q <= 1'b0;
      end
      else if (bus_stop)
      begin
        st_q  <= S_IDLE;
        low_q <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (st_q == S_ADDR || st_q == S_WOFS)
        begin
          sh_q  <= {sh_q[6:0], sda_s};
          cnt_q <= cnt_q + 4'h1;
        end
        if (st_q == S_RDATA)
          cnt_q <= cnt_q + 4'h1;
        if (st_q == S_RACK)
          mack_q <= ~sda_s;
      end
      else if (scl_fall)
      begin
        case (st_q)
          S_ADDR:
            if (byte_done)
            begin
              low_q <= addr_hit;
              rw_q  <= sh_q[0];
              st_q  <= addr_hit ? S_AACK : S_IDLE;
            end
          S_AACK:
          begin
            cnt_q <= 4'h0;
            if (rw_q)
            begin
              tx_q  <= rd_data;
              low_q <= ~rd_data[7];
              st_q  <= S_RDATA;
            end
            else
            begin
              low_q <= 1'b0;
              st_q  <= S_WOFS;
            end
          end
          S_WOFS:
            if (byte_done)
            begin
              ofs_q <= sh_q;
              low_q <= 1'b1;
              st_q  <= S_WACK;
            end
          S_WACK:
          begin
            low_q <= 1'b0;
            cnt_q <= 4'h0;
            st_q  <= S_WOFS;
          end
          S_RDATA:
            if (byte_done)
            begin
              low_q <= 1'b0;
              ofs_q <= ofs_q + 8'h01;
              st_q  <= S_RACK;
            end
            else
            begin
              tx_q  <= {tx_q[6:0], 1'b0};
              low_q <= ~tx_q[6];
            end
          S_RACK:
            if (mack_q)
            begin
              tx_q  <= rd_data;
              low_q <= ~rd_data[7];
              cnt_q <= 4'h0;
              st_q  <= S_RDATA;
            end
            else
              st_q <= S_IDLE;
          default:
            st_q <= S_IDLE;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// >>> verification/dse_display_identification_table_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dse_display_identification_table_chk
  import dse_pkg::*;
(
  // Clock and reset
  input wire logic         mclk,
  input wire logic         rst,
  // Store port
  input wire dse_st_req_t  st_req,
  input wire logic         st_done,
  // Bridged channel
  input wire dse_bcc_rsp_t ext_rsp,
  input wire dse_bcc_req_t bcc_req,
  input wire dse_bcc_rsp_t bcc_rsp,
  // Pins and status
  input wire logic         ddc_sda_o,
  input wire logic         ddc_sda_oe_n,
  input wire logic         hot_plug_indicator_o,
  input wire logic         hot_plug_indicator_oe_n,
  input wire logic         tmds_ok,
  input wire logic         cec_ref_sel,
  input wire logic         cec_tick
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [7:0] gap_q;
  logic       seen_q;
  ////////////////////////////////////////////////////////////////////////////
  // Gap only trusted after one internal tick, divider phase is free
  always_ff @(posedge mclk)
  begin
    gap_q  <= cec_tick ? 8'h00 : gap_q + 8'h01;
    seen_q <= !rst && !cec_ref_sel && (seen_q || cec_tick);
  end
  ////////////////////////////////////////////////////////////////////////////
  st_rd_done_a: assert property (st_req.req && !st_req.we |=> st_done)
    else $error("store read got no done");
  st_done_src_a: assert property (st_done |-> $past(st_req.req))
    else $error("store done without request");
  bcc_hold_a: assert property (bcc_req.req && !bcc_rsp.done
    |=> bcc_req.req && $stable(bcc_req))
    else $error("bridge request dropped early");
  ext_src_a: assert property (ext_rsp.done |-> $past(bcc_rsp.done))
    else $error("bridge answer without far answer");
  ext_pulse_a: assert property (ext_rsp.done |=> !ext_rsp.done)
    else $error("bridge answer too long");
  plug_hold_a: assert property (hot_plug_indicator_oe_n
    |-> $past(tmds_ok))
    else $error("hot plug released while not ready");
  pin_low_a: assert property (!ddc_sda_o && !hot_plug_indicator_o)
    else $error("open drain pin drives high");
  cec_gap_a: assert property (cec_tick && seen_q && !cec_ref_sel
    |-> gap_q == 8'(CEC_TICK_CYC - 1))
    else $error("internal tick spacing wrong");
  cec_ext_pulse_a: assert property (cec_tick && cec_ref_sel
    && $past(cec_ref_sel) |=> !cec_tick)
    else $error("reference tick too long");
  rst_pins_a: assert property (disable iff (1'b0) rst
    |=> ddc_sda_oe_n && !hot_plug_indicator_oe_n && !st_done)
    else $error("pins wrong after reset");
  cover property (st_done);
  cover property (ext_rsp.done && ext_rsp.nak);
  cover property (cec_tick && seen_q);
  cover property (cec_tick && cec_ref_sel);
endmodule
bind dse_display_identification_table_ctrl dse_display_identification_table_chk u_chk (.mclk, .rst, .st_req, .st_done,
  .ext_rsp, .bcc_req, .bcc_rsp, .ddc_sda_o, .ddc_sda_oe_n,
  .hot_plug_indicator_o, .hot_plug_indicator_oe_n, .tmds_ok, .cec_ref_sel,
  .cec_tick);
`default_nettype wire

// >>> verification/dse_ddc_src.sv
`timescale 1ns/1ps
`default_nettype none
module dse_ddc_src
(
  // Clock
  input wire logic mclk,
  // Device drive of the data line
  input wire logic dev_o,
  input wire logic dev_oe_n,
  // Bus levels
  output logic     scl,
  output logic     sda
);
  logic pull_q;
  // Pull-up line, so a released line reads high
  assign sda = !(pull_q || (!dev_oe_n && !dev_o));
  initial
  begin
    scl    = 1'b1;
    pull_q = 1'b0;
  end
  task automatic q;
    repeat (8) @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Data bits move while the clock is low; start and stop move data while it is high
  task automatic start;
    pull_q <= 1'b0;
    q;
    scl <= 1'b1;
    q;
    pull_q <= 1'b1;
    q;
    scl <= 1'b0;
    q;
  endtask
  task automatic stop;
    pull_q <= 1'b1;
    q;
    scl <= 1'b1;
    q;
    pull_q <= 1'b0;
    q;
  endtask
  task automatic bit_io(input logic b, output logic r);
    pull_q <= !b;
    q;
    scl <= 1'b1;
    q;
    r = sda;
    q;
    scl <= 1'b0;
    q;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai,
                      output logic [7:0] r, output logic ao);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(ai, ao);
  endtask
endmodule
`default_nettype wire

// >>> verification/dse_display_identification_table_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dse_display_identification_table_ctrl_tb_top;
  import dse_pkg::*;
  logic mclk, rst, mode_ovr_en, eep_sda_oe_n, pwr5v_pin, video_ready;
  logic tmds_div_pin;
  logic cec_ref_sel, cec_ref_pin, st_done, eep_scl_oe_n, table_ok;
  logic ddc_sda_o, ddc_sda_oe_n, hot_plug_indicator_oe_n, nak_on;
  logic [1:0]   mode_sel_pin, dly;
  logic [6:0]   exp_dev;
  logic [7:0]   st_rdata, img [256], d;
  wire logic    scl, sda;
  dse_src_t     mode_ovr;
  dse_st_req_t  st_req;
  dse_bcc_req_t ext_req, bcc_req;
  dse_bcc_rsp_t ext_rsp, bcc_rsp, r;
  int           fail_count, total_checks, n_ans, cyc, n, tper;
  // Eeprom data line pulled up, low only while the block drives it
  dse_display_identification_table_ctrl u_dut (.mclk, .rst, .mode_sel_pin, .mode_ovr_en, .mode_ovr,
    .ddc_scl_i(scl), .ddc_sda_i(sda), .ddc_sda_o, .ddc_sda_oe_n,
    .eep_sda_i(eep_sda_oe_n), .eep_scl_o(), .eep_scl_oe_n, .eep_sda_o(),
    .eep_sda_oe_n, .st_req, .st_done, .st_rdata, .ext_req, .ext_rsp,
    .bcc_req, .bcc_rsp, .pwr5v_pin, .video_ready, .tmds_div_pin,
    .hot_plug_indicator_o(), .hot_plug_indicator_oe_n, .table_ok,
    .tmds_ok(), .cec_ref_sel, .cec_ref_pin, .cec_tick());
  dse_ddc_src u_src (.mclk, .dev_o(ddc_sda_o), .dev_oe_n(ddc_sda_oe_n),
    .scl, .sda);
  always #20 mclk = ~mclk;
  function automatic logic [7:0] rem(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("ERROR %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic st(input logic we, input logic [7:0] a, w);
    @(posedge mclk) st_req <= '{1'b1, we, a, w};
    @(posedge mclk) st_req.req <= 1'b0;
    #1;
    chk("store done", st_done, 1'b1);
    d = st_rdata;
  endtask
  task automatic ext(input logic we, input logic [7:0] a);
    exp_dev = 7'($urandom);
    @(posedge mclk) ext_req <= '{1'b1, we, exp_dev, a, 8'($urandom)};
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end while (ext_rsp.done !== 1'b1 && n < 200);
    r = ext_rsp;
    @(posedge mclk) ext_req.req <= 1'b0;
  endtask
  // Offset written first, then a repeated start for the read
  task automatic ddc_rd(input logic [7:0] off, input int cnt);
    logic [7:0] b;
    logic       a;
    u_src.start;
    u_src.xfer({DDC_DEV_ADDR, 1'b0}, 1'b1, b, a);
    chk("dev ack", a, 1'b0);
    u_src.xfer(off, 1'b1, b, a);
    u_src.start;
    u_src.xfer({DDC_DEV_ADDR, 1'b1}, 1'b1, b, a);
    for (int k = 0; k < cnt; k++)
    begin
      u_src.xfer(8'hff, k == cnt - 1, b, a);
      chk("ddc byte", b, img[8'(off + k)]);
    end
    u_src.stop;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Far side of the bridge answers after a random stall
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      conclude;
    end
    cec_ref_pin <= 1'($urandom);
    // Divided link clock, inside the accepted range unless sped up
    if (cyc % tper == 0)
      tmds_div_pin <= ~tmds_div_pin;
    if (bcc_req.req && !bcc_rsp.done && dly == 2'h0)
    begin
      chk("bridge dev", 8'(bcc_req.dev), 8'(exp_dev));
      bcc_rsp <= '{1'b1, nak_on, rem(bcc_req.addr)};
      dly <= 2'($urandom);
      n_ans++;
    end
    else
    begin
      if (bcc_req.req && dly != 2'h0)
        dly <= dly - 2'h1;
      bcc_rsp <= '{1'b0, 1'b0, ~bcc_rsp.rdata};
    end
  end
  initial
  begin
    void'($urandom(24844));
    {mclk, rst, mode_sel_pin, mode_ovr_en, mode_ovr} = {2'h1, SRC_FUSED,
      1'b0, SRC_SRAM};
    {pwr5v_pin, video_ready, cec_ref_sel, nak_on, dly} = 6'h00;
    {st_req, ext_req, bcc_rsp, exp_dev, tmds_div_pin} = '0;
    tper = 16;
    exp_dev = DDC_DEV_ADDR;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    for (n = 0; n < 5000 && table_ok !== 1'b1; n++) @(posedge mclk);
    {img[0], img[1]} = 16'h00ff;
    st(1'b0, 8'h00, 8'h00);
    chk("fused 0", d, img[0]);
    ddc_rd(8'h00, 2);
    u_src.start;
    u_src.xfer(8'ha2, 1'b1, d, nak_on);
    chk("other dev", nak_on, 1'b1);
    u_src.stop;
    chk("hot plug held", hot_plug_indicator_oe_n, 1'b0);
    pwr5v_pin <= 1'b1;
    video_ready <= 1'b1;
    repeat (60) @(posedge mclk);
    chk("hot plug", hot_plug_indicator_oe_n, 1'b1);
    tper <= 1;
    repeat (2200) @(posedge mclk);
    chk("tmds too fast", hot_plug_indicator_oe_n, 1'b0);
    $display("test fused done");
    {nak_on, mode_ovr_en} <= 2'h1;
    for (int i = 0; i < STORE_DEPTH; i++)
    begin
      img[i] = 8'($urandom);
      st(1'b1, 8'(i), img[i]);
    end
    for (int i = 0; i < STORE_DEPTH; i++)
    begin
      st(1'b0, 8'(i), 8'h00);
      chk("store", d, img[i]);
    end
    ddc_rd(8'hfd, 4);
    ext(1'b0, 8'h33);
    chk("bridge data", r.rdata, rem(8'h33));
    nak_on <= 1'b1;
    ext(1'b1, 8'($urandom));
    chk("bridge nak", r.nak, 1'b1);
    nak_on <= 1'b0;
    $display("test store and bridge done");
    {exp_dev, n_ans} = {DDC_DEV_ADDR, 32'h0};
    mode_ovr <= SRC_REMOTE;
    for (n = 0; n < 8000 && (n_ans < 256 || table_ok !== 1'b1); n++)
      @(posedge mclk);
    repeat (8) @(posedge mclk);
    for (int i = 0; i < STORE_DEPTH; i++)
      img[i] = rem(8'(i));
    st(1'b0, STORE_LAST, 8'h00);
    chk("remote copy", d, img[255]);
    ddc_rd(8'h7f, 2);
    mode_ovr <= SRC_EEPROM;
    cec_ref_sel <= 1'b1;
    repeat (4) @(posedge mclk);
    u_src.start;
    chk("eeprom clock low", eep_scl_oe_n, 1'b0);
    chk("eeprom data low", eep_sda_oe_n, 1'b0);
    u_src.stop;
    chk("eeprom clock free", eep_scl_oe_n, 1'b1);
    chk("eeprom data free", eep_sda_oe_n, 1'b1);
    $display("test remote and eeprom done");
    conclude;
  end
endmodule
`default_nettype wire
